// ---- pkg/stt_pkg.sv ----
// Purpose: Shared constants for the 16-bit timer with capture/compare time base.
// Assumes: APB slave with 8-bit byte address, 32-bit data, one word per register.
// Notes:   Registers are 8 bits wide or less and sit in the low bits of each word.
package stt_pkg;

  // ----------------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_COUNT_LOW = 8'h04;
  localparam logic [7:0] OFS_COUNT_HIGH = 8'h08;
  localparam logic [7:0] OFS_CAPCOMP_LOW = 8'h0C;
  localparam logic [7:0] OFS_CAPCOMP_HIGH = 8'h10;
  localparam logic [7:0] OFS_CAPCOMP_MODE = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
  localparam logic [7:0] OFS_CORE_IRQ = 8'h20;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_WIDE_BIT = 1;
  localparam int CTRL_SYNCD_BIT = 2;
  localparam int CTRL_SOSC_BIT = 3;
  localparam int CTRL_PS_LSB = 4;
  localparam int CTRL_CS_LSB = 6;
  localparam int IRQ_OVF_BIT = 0;
  localparam int IRQ_CCP_BIT = 1;
  localparam int CORE_PEIE_BIT = 0;
  localparam int CORE_GIE_BIT = 1;

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] CS_INSTR = 2'h0;
  localparam logic [1:0] CS_SYSTEM = 2'h1;
  localparam logic [1:0] CS_PIN = 2'h2;
  localparam logic [1:0] CS_SOSC = 2'h3;
  localparam logic [1:0] CCM_OFF = 2'h0;
  localparam logic [1:0] CCM_CAPTURE = 2'h1;
  localparam logic [1:0] CCM_COMPARE = 2'h2;
  localparam logic [1:0] CCM_TRIGGER = 2'h3;

  // ----------------------------------------------------------------------
  // Counts and reset values
  // ----------------------------------------------------------------------
  localparam int CLOCK_HZ = 50_000_000;
  localparam logic [1:0] INSTR_LAST = 2'h3;
  localparam logic [1:0] DIV_STEP = 2'h1;
  localparam logic [2:0] PS_STEP = 3'h1;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_STEP = 16'h0001;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

endpackage : stt_pkg

// ---- rtl/stt_timer.sv ----
// Purpose: 16-bit up-counter with overflow interrupt, sleep wake-up and
//          capture/compare time base with special event trigger, on APB.
// Assumes: sleep_mode and special_trigger_in come from logic on clock;
//          ext_clock_pin and capture_pin are asynchronous pins.
// Notes:   APB answers with one wait state; pready, prdata, pslverr registered.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [R1] Counter counts up, wraps FFFF to 0000
// [R2] Every wrap sets the overflow flag
// [R3] Overflow interrupt needs run and three enables
// [R4] Software clears overflow flag; hardware holds it
// [R5] Software zeroes counter and flag before enabling
// [R6] In sleep count only async external clock
// [R7] Software prepares enables and clock before sleeping
// [R8] Overflow in sleep wakes; vector needs global enable
// [R9] Secondary oscillator keeps running through sleep
// [R10] Capture event copies counter into capcomp pair
// [R11] Counter equal to capcomp raises compare event
// [R12] Special event trigger clears both counter bytes
// [R13] Trigger clear never sets the overflow flag
// [R14] Capcomp pair acts as period under trigger
// [R15] Software runs timer synchronized for trigger use
// [R16] Counter write beats a coincident trigger clear
// [R17] Run bit set: count prescaled ticks, else hold
module stt_timer (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [stt_pkg::ADDR_W-1:0] paddr,
  input wire logic [stt_pkg::DATA_W-1:0] pwdata,
  output logic [stt_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_mode,
  input wire logic ext_clock_pin,
  input wire logic capture_pin,
  input wire logic special_trigger_in,
  output logic irq,
  output logic wake,
  output logic compare_event,
  output logic special_trigger_out,
  output logic sosc_run
);
  import stt_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] control;
    logic [15:0] count;
    logic [7:0] high_buf;
    logic [15:0] capval;
    logic [1:0] ccp_mode;
    logic [1:0] status;
    logic [1:0] mask;
    logic [1:0] core;
    logic [1:0] div;
    logic [2:0] pscnt;
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic cap_s1;
    logic cap_s2;
    logic cap_s3;
    logic match_prev;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic wake;
    logic compare_event;
    logic trigger_out;
    logic sosc_run;
  } stt_state_type;

  stt_state_type r_reg;
  stt_state_type r_next;

  logic count_tick;
  logic trigger;
  logic cnt_wr;
  logic match_evt;
  logic cap_rise;
  logic sleep_ok;
  logic run;

  // Prescale divides by 1, 2, 4 or 8: last value of the prescale count
  function automatic logic [2:0] ps_limit(input logic [1:0] sel);
    logic [2:0] lim;
    unique case (sel)
      2'h0: lim = 3'h0;
      2'h1: lim = 3'h1;
      2'h2: lim = 3'h3;
      2'h3: lim = 3'h7;
    endcase
    return lim;
  endfunction : ps_limit

  function automatic logic addr_mapped(input logic [7:0] a);
    return (a == OFS_CONTROL) || (a == OFS_COUNT_LOW) || (a == OFS_COUNT_HIGH) ||
           (a == OFS_CAPCOMP_LOW) || (a == OFS_CAPCOMP_HIGH) ||
           (a == OFS_CAPCOMP_MODE) || (a == OFS_IRQ_STATUS) ||
           (a == OFS_IRQ_MASK) || (a == OFS_CORE_IRQ);
  endfunction : addr_mapped

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [1:0] cs;
    logic src_tick;
    logic pin_rise;
    logic ext_src;
    logic match;
    logic wr;
    logic [1:0] w1c;
    logic [1:0] sets;
    logic [1:0] pend;
    logic any_pend;
    cs = r_reg.control[CTRL_CS_LSB +: 2];
    src_tick = 1'b0;
    w1c = 2'h0;
    sets = 2'h0;
    r_next = r_reg;
    cnt_wr = 1'b0;
    count_tick = 1'b0;
    // Locals start defined so no path leaves them to a latch
    pin_rise = 1'b0;
    ext_src = 1'b0;
    match = 1'b0;
    wr = 1'b0;
    pend = 2'h0;
    any_pend = 1'b0;

    // Pins pass two flops before any logic looks at them
    r_next.pin_s1 = ext_clock_pin;
    r_next.pin_s2 = r_reg.pin_s1;
    r_next.pin_s3 = r_reg.pin_s2;
    r_next.cap_s1 = capture_pin;
    r_next.cap_s2 = r_reg.cap_s1;
    r_next.cap_s3 = r_reg.cap_s2;
    pin_rise = r_reg.pin_s2 & ~r_reg.pin_s3;
    cap_rise = r_reg.cap_s2 & ~r_reg.cap_s3;

    // Instruction clock is one in four system clocks
    r_next.div = r_reg.div + DIV_STEP;
    unique case (cs)
      CS_INSTR: src_tick = (r_reg.div == INSTR_LAST);
      CS_SYSTEM: src_tick = 1'b1;
      CS_PIN: src_tick = pin_rise;
      CS_SOSC: src_tick = pin_rise;
    endcase

    // [R6] sleep gates the source
    ext_src = (cs == CS_PIN) || (cs == CS_SOSC);
    sleep_ok = ~sleep_mode | (r_reg.control[CTRL_SYNCD_BIT] & ext_src);
    run = r_reg.control[CTRL_RUN_BIT];

    // [R17] prescaled tick while running
    if (run && sleep_ok && src_tick) begin
      if (r_reg.pscnt == ps_limit(r_reg.control[CTRL_PS_LSB +: 2])) begin
        r_next.pscnt = 3'h0;
        count_tick = 1'b1;
      end else begin
        r_next.pscnt = r_reg.pscnt + PS_STEP;
      end
    end

    // [R11] compare event on the first cycle of equality
    match = (r_reg.count == r_reg.capval) &&
            ((r_reg.ccp_mode == CCM_COMPARE) || (r_reg.ccp_mode == CCM_TRIGGER));
    r_next.match_prev = match;
    match_evt = match & ~r_reg.match_prev;
    r_next.compare_event = match_evt;
    // [R14] capcomp pair is the period under trigger mode
    r_next.trigger_out = match_evt && (r_reg.ccp_mode == CCM_TRIGGER);
    trigger = r_next.trigger_out | special_trigger_in;
    if (match_evt) begin
      sets[IRQ_CCP_BIT] = 1'b1;
    end

    // [R12] trigger clears, [R13] with no overflow flag
    if (trigger) begin
      r_next.count = COUNT_ZERO;
    end else if (count_tick) begin
      // [R1] natural 16-bit wrap
      r_next.count = r_reg.count + COUNT_STEP;
      // [R2] overflow flag on wrap
      if (r_reg.count == COUNT_MAX) begin
        sets[IRQ_OVF_BIT] = 1'b1;
      end
    end

    // APB: first access cycle loads the answer, second completes
    wr = psel & penable & r_reg.pready & pwrite;
    r_next.pready = psel & penable & ~r_reg.pready;
    r_next.pslverr = psel & penable & ~r_reg.pready & ~addr_mapped(paddr);
    if (psel && penable && !r_reg.pready && !pwrite) begin
      r_next.prdata = 32'h0000_0000;
      unique case (paddr)
        OFS_CONTROL: r_next.prdata[7:0] = r_reg.control;
        OFS_COUNT_LOW: begin
          r_next.prdata[7:0] = r_reg.count[7:0];
          // Wide reads freeze the high byte so both halves agree
          if (r_reg.control[CTRL_WIDE_BIT]) begin
            r_next.high_buf = r_reg.count[15:8];
          end
        end
        OFS_COUNT_HIGH: begin
          r_next.prdata[7:0] = r_reg.control[CTRL_WIDE_BIT] ? r_reg.high_buf
                                                             : r_reg.count[15:8];
        end
        OFS_CAPCOMP_LOW: r_next.prdata[7:0] = r_reg.capval[7:0];
        OFS_CAPCOMP_HIGH: r_next.prdata[7:0] = r_reg.capval[15:8];
        OFS_CAPCOMP_MODE: r_next.prdata[1:0] = r_reg.ccp_mode;
        OFS_IRQ_STATUS: r_next.prdata[1:0] = r_reg.status;
        OFS_IRQ_MASK: r_next.prdata[1:0] = r_reg.mask;
        OFS_CORE_IRQ: r_next.prdata[1:0] = r_reg.core;
        default: r_next.prdata = 32'h0000_0000;
      endcase
    end

    if (wr) begin
      unique case (paddr)
        OFS_CONTROL: r_next.control = pwdata[7:0];
        // [R16] a counter write overrides the trigger clear
        OFS_COUNT_LOW: begin
          cnt_wr = 1'b1;
          r_next.pscnt = 3'h0;
          r_next.count[7:0] = pwdata[7:0];
          if (r_reg.control[CTRL_WIDE_BIT]) begin
            r_next.count[15:8] = r_reg.high_buf;
          end else begin
            // Untouched byte keeps its old value, not the trigger clear
            r_next.count[15:8] = r_reg.count[15:8];
          end
        end
        OFS_COUNT_HIGH: begin
          if (r_reg.control[CTRL_WIDE_BIT]) begin
            r_next.high_buf = pwdata[7:0];
          end else begin
            cnt_wr = 1'b1;
            r_next.pscnt = 3'h0;
            r_next.count[15:8] = pwdata[7:0];
            r_next.count[7:0] = r_reg.count[7:0];
          end
        end
        OFS_CAPCOMP_LOW: r_next.capval[7:0] = pwdata[7:0];
        OFS_CAPCOMP_HIGH: r_next.capval[15:8] = pwdata[7:0];
        OFS_CAPCOMP_MODE: r_next.ccp_mode = pwdata[1:0];
        OFS_IRQ_STATUS: w1c = pwdata[1:0];
        OFS_IRQ_MASK: r_next.mask = pwdata[1:0];
        OFS_CORE_IRQ: r_next.core = pwdata[1:0];
        default: cnt_wr = 1'b0;
      endcase
    end

    // [R10] capture copies the counter; beats a bus write to the pair
    if (cap_rise && (r_reg.ccp_mode == CCM_CAPTURE)) begin
      r_next.capval = r_reg.count;
      sets[IRQ_CCP_BIT] = 1'b1;
    end

    // [R4] flags stay until written with a one; a new event wins
    r_next.status = (r_reg.status & ~w1c) | sets;

    // [R3] overflow interrupt needs run plus all enables; capture/compare needs only the enables
    pend = r_next.status & r_next.mask;
    any_pend = (pend[IRQ_OVF_BIT] & r_next.control[CTRL_RUN_BIT]) | pend[IRQ_CCP_BIT];
    r_next.irq = any_pend & r_next.core[CORE_PEIE_BIT] & r_next.core[CORE_GIE_BIT];
    // [R8] wake does not depend on the global enable
    r_next.wake = any_pend & r_next.core[CORE_PEIE_BIT] & sleep_mode;
    // [R9] oscillator follows its enable alone, sleep or not
    r_next.sosc_run = r_next.control[CTRL_SOSC_BIT];
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign irq = r_reg.irq;
  assign wake = r_reg.wake;
  assign compare_event = r_reg.compare_event;
  assign special_trigger_out = r_reg.trigger_out;
  assign sosc_run = r_reg.sosc_run;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_wrap_step;
    count_tick && !trigger && !cnt_wr && (r_reg.count == COUNT_MAX);
  endsequence

  sequence s_sleep_overflow;
    sleep_mode && r_reg.status[IRQ_OVF_BIT] && r_reg.mask[IRQ_OVF_BIT] && run &&
    r_reg.core[CORE_PEIE_BIT] && !(psel && penable && r_reg.pready && pwrite);
  endsequence

  // [R1]
  wrap_zero_a: assert property (@(posedge clock) disable iff (!arst_n) // [R1]
    s_wrap_step |=> (r_reg.count == COUNT_ZERO))
    else $error("counter did not wrap to zero");

  // [R2]
  ovf_flag_set_a: assert property (@(posedge clock) disable iff (!arst_n) // [R2]
    s_wrap_step |=> r_reg.status[IRQ_OVF_BIT])
    else $error("overflow flag not set on wrap");

  // [R3]
  irq_gate_a: assert property (@(posedge clock) disable iff (!arst_n) // [R3]
    irq |-> r_reg.core[CORE_GIE_BIT] && r_reg.core[CORE_PEIE_BIT] &&
      ((r_reg.status & r_reg.mask) != 2'h0))
    else $error("interrupt raised without its enables");

  // [R6]
  sleep_hold_a: assert property (@(posedge clock) disable iff (!arst_n) // [R6]
    !sleep_ok && !cnt_wr && !trigger |=> $stable(r_reg.count))
    else $error("counter moved in sleep without async clock");

  // [R8]
  wake_a: assert property (@(posedge clock) disable iff (!arst_n) // [R8]
    s_sleep_overflow |=> wake)
    else $error("overflow in sleep did not wake");

  // [R10]
  capture_a: assert property (@(posedge clock) disable iff (!arst_n) // [R10]
    cap_rise && (r_reg.ccp_mode == CCM_CAPTURE) |=> r_reg.capval == $past(r_reg.count))
    else $error("capture did not copy counter");

  // [R11]
  compare_a: assert property (@(posedge clock) disable iff (!arst_n) // [R11]
    match_evt |=> compare_event && r_reg.status[IRQ_CCP_BIT])
    else $error("compare match raised no event");

  // [R12]
  trigger_clear_a: assert property (@(posedge clock) disable iff (!arst_n) // [R12]
    trigger && !cnt_wr && !r_reg.status[IRQ_OVF_BIT] && !count_tick |=>
      (r_reg.count == COUNT_ZERO) && !r_reg.status[IRQ_OVF_BIT])
    else $error("trigger clear wrong or set overflow flag");

  // [R16]
  write_wins_a: assert property (@(posedge clock) disable iff (!arst_n) // [R16]
    trigger && cnt_wr && (paddr == OFS_COUNT_LOW) |=>
      r_reg.count[7:0] == $past(pwdata[7:0]))
    else $error("trigger overrode a counter write");

  // [R17]
  run_hold_a: assert property (@(posedge clock) disable iff (!arst_n) // [R17]
    !run && !cnt_wr && !trigger |=> $stable(r_reg.count))
    else $error("counter moved while stopped");

  // [R9]
  osc_follow_a: assert property (@(posedge clock) disable iff (!arst_n) // [R9]
    sleep_mode && r_reg.control[CTRL_SOSC_BIT] && !(psel && penable && pready && pwrite) |=>
      sosc_run)
    else $error("secondary oscillator stopped in sleep");

  apb_answer_a: assert property (@(posedge clock) disable iff (!arst_n)
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("APB answer not one wait state");

endmodule : stt_timer

`default_nettype wire

// ---- verification/stt_far_model.sv ----
// Purpose: Far side of the timer: external clock pin, capture pin, neighbour trigger.
// Assumes: Requests come from the bench as levels on the bus clock.
// Notes:   The external clock stands still unless ext_run is high.
`timescale 1ns/1ps
`default_nettype none
module stt_far_model (
  input wire logic clock,
  input wire logic ext_run,
  input wire logic cap_req,
  input wire logic trig_req,
  output logic ext_clock_pin,
  output logic capture_pin,
  output logic special_trigger_in
);
  // ----------------------------------------------------------------
  // Pin behaviour
  // ----------------------------------------------------------------
  initial begin
    ext_clock_pin = 1'b0;
    capture_pin = 1'b0;
    special_trigger_in = 1'b0;
  end
  // external clock, phase unrelated to the bus clock
  // Toggles at 25 ns past a 30 ns grid, so never on a bus clock edge
  always begin
    #25;
    if (ext_run) ext_clock_pin = ~ext_clock_pin;
    #5;
  end
  always @(posedge clock) capture_pin <= cap_req;
  // neighbour trigger, one cycle per request cycle
  always @(posedge clock) special_trigger_in <= trig_req;
endmodule : stt_far_model
`default_nettype wire

// ---- verification/tb_top.sv ----
// Purpose: Self-checking bench for the timer block over APB.
// Assumes: One wait state per transfer; far side from stt_far_model.
// Notes:   Offsets and bit layout come from stt_pkg.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import stt_pkg::*;
  // ----------------------------------------------------------------
  // Bench
  // ----------------------------------------------------------------
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep_mode = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata, rdat;
  logic pready, pslverr, ext_clock_pin, capture_pin, special_trigger_in, rerr;
  logic irq, wake, compare_event, special_trigger_out, sosc_run;
  logic ext_run = 1'b0, cap_req = 1'b0, trig_req = 1'b0;
  int failures = 0, num_checks = 0, cycles = 0, cmp_seen = 0, trig_seen = 0, c0, t0;

  always #10 clock = ~clock;

  stt_timer stt_timer_inst (.clock(clock), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
    .ext_clock_pin(ext_clock_pin), .capture_pin(capture_pin),
    .special_trigger_in(special_trigger_in), .irq(irq), .wake(wake),
    .compare_event(compare_event), .special_trigger_out(special_trigger_out),
    .sosc_run(sosc_run));

  stt_far_model stt_far_model_inst (.clock(clock), .ext_run(ext_run),
    .cap_req(cap_req), .trig_req(trig_req), .ext_clock_pin(ext_clock_pin),
    .capture_pin(capture_pin), .special_trigger_in(special_trigger_in));

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (compare_event === 1'b1) cmp_seen <= cmp_seen + 1;
    if (special_trigger_out === 1'b1) trig_seen <= trig_seen + 1;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end

  // A trigger request raised with penable lands in the cycle the write takes effect
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic tg);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    trig_req <= tg;
    do begin
      @(posedge clock);
      n++;
      trig_req <= 1'b0;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) failures++;
  endtask : apb

  task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected reg %h: expected %h, seen %h", a, e, g);
    end
  endtask : chk

  task automatic chk_pin(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %b, seen %b", nm, e, g);
    end
  endtask : chk_pin

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 1'b0);
    chk(a, e, rdat);
    chk_pin("pslverr", 1'b0, rerr);
  endtask : rd_chk

  initial begin
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    rd_chk(OFS_CONTROL, 32'h0);
    rd_chk(OFS_COUNT_LOW, 32'h0);
    rd_chk(OFS_IRQ_STATUS, 32'h0);
    apb(1'b0, 8'h40, 32'h0, 1'b0);
    chk_pin("pslverr", 1'b1, rerr);
    chk(8'h40, 32'h0, rdat);
    $display("test reset done");
    wr(OFS_COUNT_LOW, 32'hFE);
    wr(OFS_COUNT_HIGH, 32'hFF);
    wr(OFS_IRQ_STATUS, 32'h3);
    wr(OFS_CONTROL, 32'h41);
    rd_chk(OFS_IRQ_STATUS, 32'h1);
    rd_chk(OFS_COUNT_HIGH, 32'h0);
    wr(OFS_IRQ_MASK, 32'h1);
    // irq is launched at the edge the write lands: look once it has settled
    wr(OFS_CORE_IRQ, 32'h3);
    @(negedge clock);
    chk_pin("irq", 1'b1, irq);
    wr(OFS_CORE_IRQ, 32'h1);
    @(negedge clock);
    chk_pin("irq", 1'b0, irq);
    wr(OFS_CORE_IRQ, 32'h3);
    wr(OFS_CONTROL, 32'h0);
    @(negedge clock);
    chk_pin("irq", 1'b0, irq);
    rd_chk(OFS_IRQ_STATUS, 32'h1);
    wr(OFS_IRQ_STATUS, 32'h1);
    rd_chk(OFS_IRQ_STATUS, 32'h0);
    wr(OFS_COUNT_LOW, 32'h42);
    repeat (20) @(posedge clock);
    rd_chk(OFS_COUNT_LOW, 32'h42);
    $display("test overflow done");
    wr(OFS_COUNT_LOW, 32'h0);
    wr(OFS_COUNT_HIGH, 32'h0);
    wr(OFS_CAPCOMP_LOW, 32'h10);
    wr(OFS_CAPCOMP_HIGH, 32'h0);
    wr(OFS_CAPCOMP_MODE, {30'h0, CCM_TRIGGER});
    wr(OFS_IRQ_STATUS, 32'h3);
    c0 = cmp_seen;
    t0 = trig_seen;
    wr(OFS_CONTROL, 32'h01);
    repeat (400) @(posedge clock);
    wr(OFS_CONTROL, 32'h0);
    apb(1'b0, OFS_COUNT_LOW, 32'h0, 1'b0);
    chk_pin("count bound", 1'b1, rdat[7:0] <= 8'h10);
    rd_chk(OFS_COUNT_HIGH, 32'h0);
    rd_chk(OFS_IRQ_STATUS, 32'h2);
    chk_pin("compare seen", 1'b1, cmp_seen > c0);
    chk_pin("trigger seen", 1'b1, trig_seen > t0);
    $display("test trigger done");
    wr(OFS_CAPCOMP_MODE, {30'h0, CCM_CAPTURE});
    wr(OFS_COUNT_LOW, 32'h34);
    wr(OFS_COUNT_HIGH, 32'h12);
    cap_req <= 1'b1;
    repeat (6) @(posedge clock);
    cap_req <= 1'b0;
    repeat (6) @(posedge clock);
    rd_chk(OFS_CAPCOMP_LOW, 32'h34);
    rd_chk(OFS_CAPCOMP_HIGH, 32'h12);
    wr(OFS_CAPCOMP_MODE, {30'h0, CCM_OFF});
    wr(OFS_COUNT_LOW, 32'h55);
    wr(OFS_COUNT_HIGH, 32'h55);
    wr(OFS_IRQ_STATUS, 32'h3);
    trig_req <= 1'b1;
    @(posedge clock);
    trig_req <= 1'b0;
    repeat (3) @(posedge clock);
    rd_chk(OFS_COUNT_LOW, 32'h0);
    rd_chk(OFS_COUNT_HIGH, 32'h0);
    rd_chk(OFS_IRQ_STATUS, 32'h0);
    apb(1'b1, OFS_COUNT_LOW, 32'h77, 1'b1);
    rd_chk(OFS_COUNT_LOW, 32'h77);
    $display("test capture done");
    wr(OFS_COUNT_LOW, 32'hFF);
    wr(OFS_COUNT_HIGH, 32'hFF);
    wr(OFS_IRQ_STATUS, 32'h3);
    wr(OFS_CORE_IRQ, 32'h1);
    sleep_mode <= 1'b1;
    wr(OFS_CONTROL, 32'h8D);
    ext_run <= 1'b1;
    repeat (60) @(posedge clock);
    ext_run <= 1'b0;
    repeat (8) @(posedge clock);
    chk_pin("wake", 1'b1, wake);
    chk_pin("irq", 1'b0, irq);
    chk_pin("sosc_run", 1'b1, sosc_run);
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_IRQ_STATUS, 32'h1);
    wr(OFS_COUNT_LOW, 32'h07);
    wr(OFS_CONTROL, 32'h41);
    repeat (20) @(posedge clock);
    rd_chk(OFS_COUNT_LOW, 32'h07);
    sleep_mode <= 1'b0;
    wr(OFS_CONTROL, 32'h0);
    $display("test sleep done");
    // System clock divided by 8 for 84 running edges gives 10 counts
    wr(OFS_COUNT_LOW, 32'h0);
    wr(OFS_COUNT_HIGH, 32'h0);
    wr(OFS_CONTROL, 32'h71);
    repeat (80) @(posedge clock);
    wr(OFS_CONTROL, 32'h0);
    rd_chk(OFS_COUNT_LOW, 32'h0A);
    rd_chk(OFS_COUNT_HIGH, 32'h0);
    $display("test prescale done");
    // Wide mode: high byte goes through the buffer on write and read
    wr(OFS_CONTROL, 32'h02);
    wr(OFS_COUNT_HIGH, 32'hAB);
    wr(OFS_COUNT_LOW, 32'hCD);
    rd_chk(OFS_COUNT_LOW, 32'hCD);
    rd_chk(OFS_COUNT_HIGH, 32'hAB);
    wr(OFS_CONTROL, 32'h0);
    $display("test wide done");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
